// ### rtl/ptf_pulse_timers.sv
// Wiping relay, edge-triggered wiping relay and async pulse generator, AXI4-Lite registers.
// Assumes function inputs are asynchronous pins; bus on i_mclk.
`timescale 1ns/100ps
`include "ptf_cfg.svh"
module ptf_pulse_timers
(
	// Clock and reset
	input  wire logic                 i_mclk,
	input  wire logic                 i_sys_rst,
	// Function inputs
	input  wire logic                 i_wipe_trg,
	input  wire logic                 i_etw_trg,
	input  wire logic                 i_etw_rst,
	input  wire logic                 i_apg_en,
	input  wire logic                 i_apg_inv,
	// Function outputs
	output logic                      o_wipe_q,
	output logic                      o_etw_q,
	output logic                      o_apg_q,
	// AXI4-Lite write
	input  wire logic [`PTF_AW-1:0]   i_axi_awaddr,
	input  wire logic                 i_axi_awvalid,
	output logic                      o_axi_awready,
	input  wire logic [31:0]          i_axi_wdata,
	input  wire logic [3:0]           i_axi_wstrb,
	input  wire logic                 i_axi_wvalid,
	output logic                      o_axi_wready,
	output logic [1:0]                o_axi_bresp,
	output logic                      o_axi_bvalid,
	input  wire logic                 i_axi_bready,
	// AXI4-Lite read
	input  wire logic [`PTF_AW-1:0]   i_axi_araddr,
	input  wire logic                 i_axi_arvalid,
	output logic                      o_axi_arready,
	output logic [31:0]               o_axi_rdata,
	output logic [1:0]                o_axi_rresp,
	output logic                      o_axi_rvalid,
	input  wire logic                 i_axi_rready
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	ptf_tick_if tb ();

	logic [4:0]                   pin_s1_q;
	logic [4:0]                   pin_s2_q;
	logic [4:0]                   pin_d_q;
	logic                         tick;

	logic                         aw_have_q;
	logic [`PTF_AW-1:0]           aw_addr_q;
	logic                         w_have_q;
	logic [31:0]                  w_data_q;
	logic [3:0]                   w_strb_q;
	logic                         do_wr;
	logic [31:0]                  wr_val;

	logic [2:0]                   ret_q;
	logic                         restart_q;
	logic [`PTF_TW-1:0]           tbase_q;
	ptf_pkg::ptf_span_type        span_q [`PTF_NSPAN];
	ptf_pkg::ptf_time_type        span_v [`PTF_NSPAN];
	logic [3:0]                   count_q;

	ptf_pkg::ptf_time_type        wipe_ta_q;
	logic                         wipe_rise;
	logic                         wipe_clr;

	ptf_pkg::ptf_etw_state_type   etw_state_q;
	ptf_pkg::ptf_time_type        etw_ta_q;
	logic [3:0]                   etw_left_q;
	logic                         etw_rise;
	logic                         etw_clr;

	ptf_pkg::ptf_time_type        apg_ta_q;
	logic                         apg_hi_q;
	logic                         apg_flip;
	logic                         apg_clr;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic ptf_pkg::ptf_time_type span_of(input ptf_pkg::ptf_span_type sp,
		input ptf_pkg::ptf_time_type t0, input ptf_pkg::ptf_time_type t1,
		input ptf_pkg::ptf_time_type t2);
		case (sp[`PTF_SRC_MSB:`PTF_SRC_LSB])
			`PTF_SRC_CONST: span_of = sp[`PTF_TW-1:0];
			`PTF_SRC_WIPE:  span_of = t0;
			`PTF_SRC_ETW:   span_of = t1;
			default:        span_of = t2;
		endcase
	endfunction

	function automatic logic in_range(input logic [`PTF_AW-1:0] a,
		input logic [`PTF_AW-1:0] lo, input logic [`PTF_AW-1:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [2:0] slot_of(input logic [`PTF_AW-1:0] a,
		input logic [`PTF_AW-1:0] base);
		logic [`PTF_AW-1:0] off;
		off     = a - base;
		slot_of = off[4:2];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				merge[i*8 +: 8] = nw[i*8 +: 8];
	endfunction

	// ----------------------------------------
	// Pin synchronisers and timebase
	// ----------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_d_q  <= '0;
		end
		else
		begin
			pin_s1_q <= {i_apg_inv, i_apg_en, i_etw_rst, i_etw_trg, i_wipe_trg};
			pin_s2_q <= pin_s1_q;
			pin_d_q  <= pin_s2_q;
		end
	end

	assign wipe_rise  = pin_s2_q[`PTF_PIN_WIPE_TRG] & ~pin_d_q[`PTF_PIN_WIPE_TRG];
	assign etw_rise   = pin_s2_q[`PTF_PIN_ETW_TRG] & ~pin_d_q[`PTF_PIN_ETW_TRG];
	assign tb.divisor = tbase_q;
	assign tick       = tb.tick;

	ptf_timebase u_timebase
	(
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.tb        (tb)
	);

	// Live span values
	genvar g;
	generate
		for (g = 0; g < `PTF_NSPAN; g++)
		begin : g_span
			assign span_v[g] = span_of(span_q[g], wipe_ta_q, etw_ta_q, apg_ta_q);
		end
	endgenerate

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	assign o_axi_awready = ~aw_have_q & ~o_axi_bvalid;
	assign o_axi_wready  = ~w_have_q & ~o_axi_bvalid;
	assign do_wr         = aw_have_q & w_have_q & ~o_axi_bvalid;

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			aw_have_q    <= 1'b0;
			aw_addr_q    <= '0;
			w_have_q     <= 1'b0;
			w_data_q     <= '0;
			w_strb_q     <= '0;
			o_axi_bvalid <= 1'b0;
			o_axi_bresp  <= `PTF_RESP_OKAY;
		end
		else
		begin
			if (i_axi_awvalid && o_axi_awready)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= {i_axi_awaddr[`PTF_AW-1:2], 2'b00};
			end
			if (i_axi_wvalid && o_axi_wready)
			begin
				w_have_q <= 1'b1;
				w_data_q <= i_axi_wdata;
				w_strb_q <= i_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				o_axi_bvalid <= 1'b1;
				o_axi_bresp  <= in_range(aw_addr_q, `PTF_ADDR_CTRL, `PTF_ADDR_COUNT) ?
					`PTF_RESP_OKAY : `PTF_RESP_SLVERR;
			end
			else if (o_axi_bvalid && i_axi_bready)
				o_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_comb
	begin
		case (aw_addr_q)
			`PTF_ADDR_CTRL:  wr_val = merge({25'h0, ret_q, 4'h0}, w_data_q, w_strb_q);
			`PTF_ADDR_TBASE: wr_val = merge({16'h0, tbase_q}, w_data_q, w_strb_q);
			`PTF_ADDR_COUNT: wr_val = merge({28'h0, count_q}, w_data_q, w_strb_q);
			default:         wr_val = merge({14'h0, span_q[slot_of(aw_addr_q, `PTF_ADDR_SPAN0)]},
				w_data_q, w_strb_q);
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			ret_q     <= '0;
			restart_q <= 1'b0;
			tbase_q   <= `PTF_TBASE_RST;
			count_q   <= `PTF_CNT_MIN;
			for (int i = 0; i < `PTF_NSPAN; i++)
				span_q[i] <= `PTF_SPAN_RST;
		end
		else
		begin
			restart_q <= do_wr && aw_addr_q == `PTF_ADDR_CTRL && wr_val[`PTF_CTRL_RESTART];
			if (do_wr)
			begin
				if (aw_addr_q == `PTF_ADDR_CTRL)
					ret_q <= wr_val[`PTF_CTRL_RET_MSB:`PTF_CTRL_RET_LSB];
				if (aw_addr_q == `PTF_ADDR_TBASE)
					tbase_q <= wr_val[`PTF_TW-1:0];
				if (aw_addr_q == `PTF_ADDR_COUNT)
				begin
					if (wr_val[31:4] == '0 && wr_val[3:0] < `PTF_CNT_MIN)
						count_q <= `PTF_CNT_MIN;
					else if (wr_val[31:4] != '0 || wr_val[3:0] > `PTF_CNT_MAX)
						count_q <= `PTF_CNT_MAX;
					else
						count_q <= wr_val[3:0];
				end
				if (in_range(aw_addr_q, `PTF_ADDR_SPAN0, `PTF_ADDR_SPANN))
					span_q[slot_of(aw_addr_q, `PTF_ADDR_SPAN0)] <= wr_val[`PTF_SRC_MSB:0];
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	assign o_axi_arready = ~o_axi_rvalid;

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			o_axi_rvalid <= 1'b0;
			o_axi_rdata  <= '0;
			o_axi_rresp  <= `PTF_RESP_OKAY;
		end
		else if (i_axi_arvalid && o_axi_arready)
		begin
			o_axi_rvalid <= 1'b1;
			o_axi_rresp  <= `PTF_RESP_OKAY;
			o_axi_rdata  <= '0;
			case ({i_axi_araddr[`PTF_AW-1:2], 2'b00})
				`PTF_ADDR_CTRL:  o_axi_rdata <= {25'h0, ret_q, 4'h0};
				`PTF_ADDR_TBASE: o_axi_rdata <= {16'h0, tbase_q};
				`PTF_ADDR_COUNT: o_axi_rdata <= {28'h0, count_q};
				`PTF_ADDR_STAT:  o_axi_rdata <= {22'h0, etw_left_q, etw_state_q, apg_hi_q,
					o_apg_q, o_etw_q, o_wipe_q};
				`PTF_ADDR_TA0:   o_axi_rdata <= {16'h0, wipe_ta_q};
				`PTF_ADDR_TA0 + 8'h04: o_axi_rdata <= {16'h0, etw_ta_q};
				`PTF_ADDR_TAN:   o_axi_rdata <= {16'h0, apg_ta_q};
				default:
				begin
					if (in_range({i_axi_araddr[`PTF_AW-1:2], 2'b00}, `PTF_ADDR_SPAN0, `PTF_ADDR_SPANN))
						o_axi_rdata <= {14'h0,
							span_q[slot_of({i_axi_araddr[`PTF_AW-1:2], 2'b00}, `PTF_ADDR_SPAN0)]};
					else
						o_axi_rresp <= `PTF_RESP_SLVERR;
				end
			endcase
		end
		else if (o_axi_rvalid && i_axi_rready)
			o_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------
	// Wiping relay
	// ----------------------------------------
	assign wipe_clr = restart_q & ~ret_q[`PTF_BLK_WIPE];

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst || wipe_clr)
		begin
			o_wipe_q  <= 1'b0;
			wipe_ta_q <= '0;
		end
		else if (wipe_rise)
		begin
			o_wipe_q  <= 1'b1;
			wipe_ta_q <= '0;
		end
		else if (o_wipe_q)
		begin
			if (!pin_s2_q[`PTF_PIN_WIPE_TRG])
				o_wipe_q <= 1'b0;
			else if (wipe_ta_q >= span_v[`PTF_SPAN_WIPE])
				o_wipe_q <= 1'b0;
			else if (tick)
				wipe_ta_q <= wipe_ta_q + 1'b1;
		end
	end

	// ----------------------------------------
	// Edge-triggered wiping relay
	// ----------------------------------------
	assign etw_clr = restart_q & ~ret_q[`PTF_BLK_ETW];

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst || etw_clr || pin_s2_q[`PTF_PIN_ETW_RST])
		begin
			etw_state_q <= ptf_pkg::ETW_IDLE;
			etw_ta_q    <= '0;
			etw_left_q  <= '0;
			o_etw_q     <= 1'b0;
		end
		else if (etw_rise)
		begin
			etw_state_q <= ptf_pkg::ETW_LOW;
			etw_ta_q    <= '0;
			etw_left_q  <= count_q;
			o_etw_q     <= 1'b0;
		end
		else
		begin
			case (etw_state_q)
				ptf_pkg::ETW_LOW:
				begin
					if (etw_ta_q >= span_v[`PTF_SPAN_ETW_LO])
					begin
						etw_state_q <= ptf_pkg::ETW_HIGH;
						etw_ta_q    <= '0;
						o_etw_q     <= 1'b1;
					end
					else if (tick)
						etw_ta_q <= etw_ta_q + 1'b1;
				end
				ptf_pkg::ETW_HIGH:
				begin
					if (etw_ta_q >= span_v[`PTF_SPAN_ETW_HI])
					begin
						o_etw_q     <= 1'b0;
						etw_ta_q    <= '0;
						etw_left_q  <= etw_left_q - 1'b1;
						etw_state_q <= (etw_left_q <= `PTF_CNT_MIN) ? ptf_pkg::ETW_IDLE : ptf_pkg::ETW_LOW;
					end
					else if (tick)
						etw_ta_q <= etw_ta_q + 1'b1;
				end
				default:
					o_etw_q <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// Asynchronous pulse generator
	// ----------------------------------------
	assign apg_clr  = restart_q & ~ret_q[`PTF_BLK_APG];
	assign apg_flip = apg_hi_q ? (apg_ta_q >= span_v[`PTF_SPAN_APG_HI]) :
		(apg_ta_q >= span_v[`PTF_SPAN_APG_LO]);

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst || apg_clr || !pin_s2_q[`PTF_PIN_APG_EN])
		begin
			apg_hi_q <= 1'b1;
			apg_ta_q <= '0;
			o_apg_q  <= 1'b0;
		end
		else
		begin
			if (apg_flip)
			begin
				apg_hi_q <= ~apg_hi_q;
				apg_ta_q <= '0;
			end
			else if (tick)
				apg_ta_q <= apg_ta_q + 1'b1;
			o_apg_q <= (apg_hi_q ^ apg_flip) ^ pin_s2_q[`PTF_PIN_APG_INV];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	chk_wipe_start: assert property (
		wipe_rise && !wipe_clr |=> o_wipe_q && wipe_ta_q == '0)
		else $error("wiping relay did not start on trigger edge");
	chk_wipe_span: assert property (
		o_wipe_q && !wipe_rise && wipe_ta_q == span_v[`PTF_SPAN_WIPE] |=> !o_wipe_q)
		else $error("wiping relay output outlived its span");
	chk_wipe_fall: assert property (
		o_wipe_q && !pin_s2_q[`PTF_PIN_WIPE_TRG] |=> !o_wipe_q)
		else $error("wiping relay output outlived trigger");
	chk_restart_clear: assert property (
		restart_q && !ret_q[`PTF_BLK_WIPE] |=> !o_wipe_q && wipe_ta_q == '0)
		else $error("non-retentive restart left wiping relay state");
	chk_etw_restart: assert property (
		etw_rise && !pin_s2_q[`PTF_PIN_ETW_RST] && !etw_clr
		|=> etw_state_q == ptf_pkg::ETW_LOW && etw_ta_q == '0 && !o_etw_q)
		else $error("edge relay did not restart from low phase");
	chk_etw_count: assert property (
		etw_state_q != ptf_pkg::ETW_IDLE |-> etw_left_q >= `PTF_CNT_MIN && etw_left_q <= `PTF_CNT_MAX)
		else $error("edge relay cycle count out of range");
	chk_etw_reset: assert property (
		pin_s2_q[`PTF_PIN_ETW_RST] |=> !o_etw_q && etw_ta_q == '0)
		else $error("edge relay reset input ignored");
	chk_apg_stop: assert property (
		!pin_s2_q[`PTF_PIN_APG_EN] |=> !o_apg_q && apg_hi_q)
		else $error("pulse generator active while disabled");
	chk_apg_invert: assert property (
		pin_s2_q[`PTF_PIN_APG_EN] && !restart_q |=> o_apg_q == (apg_hi_q ^ $past(pin_s2_q[`PTF_PIN_APG_INV])))
		else $error("pulse generator polarity wrong");
	chk_apg_toggle: assert property (
		pin_s2_q[`PTF_PIN_APG_EN] && !restart_q && apg_hi_q && apg_ta_q == span_v[`PTF_SPAN_APG_HI]
		|=> !apg_hi_q && apg_ta_q == '0)
		else $error("pulse generator missed end of high phase");
endmodule // ptf_pulse_timers

// ### rtl/ptf_timebase.sv
// Timebase tick generator: one tick every divisor+1 clocks.
// Assumes the divisor is a register on the same clock.
`timescale 1ns/100ps
`include "ptf_cfg.svh"
module ptf_timebase
(
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_sys_rst,
	// Timebase link
	ptf_tick_if.gen   tb
);
	logic [`PTF_TW-1:0] cnt_q;
	logic               tick_q;

	assign tb.tick = tick_q;

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else if (cnt_q >= tb.divisor)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end
endmodule // ptf_timebase

// ### shared/ptf_cfg.svh
// Address map, field positions, reset values and limits of the pulse timer block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PTF_CFG_SVH
`define PTF_CFG_SVH

`define PTF_AW          8
`define PTF_TW          16
`define PTF_NSPAN       5

// Register byte addresses
`define PTF_ADDR_CTRL   8'h00
`define PTF_ADDR_TBASE  8'h04
`define PTF_ADDR_SPAN0  8'h08
`define PTF_ADDR_SPANN  8'h18
`define PTF_ADDR_COUNT  8'h1C
`define PTF_ADDR_STAT   8'h20
`define PTF_ADDR_TA0    8'h24
`define PTF_ADDR_TAN    8'h2C

// Span slots
`define PTF_SPAN_WIPE   3'h0
`define PTF_SPAN_ETW_HI 3'h1
`define PTF_SPAN_ETW_LO 3'h2
`define PTF_SPAN_APG_HI 3'h3
`define PTF_SPAN_APG_LO 3'h4

// Span fields and duration sources
`define PTF_SRC_MSB     17
`define PTF_SRC_LSB     16
`define PTF_SRC_CONST   2'h0
`define PTF_SRC_WIPE    2'h1
`define PTF_SRC_ETW     2'h2

// Control fields
`define PTF_CTRL_RESTART 0
`define PTF_CTRL_RET_LSB 4
`define PTF_CTRL_RET_MSB 6
`define PTF_BLK_WIPE    0
`define PTF_BLK_ETW     1
`define PTF_BLK_APG     2

// Pin slots
`define PTF_PIN_WIPE_TRG 0
`define PTF_PIN_ETW_TRG  1
`define PTF_PIN_ETW_RST  2
`define PTF_PIN_APG_EN   3
`define PTF_PIN_APG_INV  4

// Reset values and limits
`define PTF_TBASE_RST   16'h03E7
`define PTF_SPAN_RST    18'h0_000A
`define PTF_CNT_MIN     4'h1
`define PTF_CNT_MAX     4'h9
`define PTF_RESP_OKAY   2'h0
`define PTF_RESP_SLVERR 2'h2

`endif

// ### shared/ptf_pkg.sv
// Types shared by the pulse timer block.
// Assumes ptf_cfg.svh on the include path.
`include "ptf_cfg.svh"
package ptf_pkg;
	typedef enum logic [1:0] {ETW_IDLE, ETW_LOW, ETW_HIGH} ptf_etw_state_type;
	typedef logic [`PTF_TW-1:0] ptf_time_type;
	typedef logic [`PTF_SRC_MSB:0] ptf_span_type;
endpackage

// ### shared/ptf_tick_if.sv
// Timebase divisor and tick between the register file and the tick generator.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`include "ptf_cfg.svh"
interface ptf_tick_if;
	logic [`PTF_TW-1:0] divisor;
	logic               tick;
	modport gen (input divisor, output tick);
	modport use_tick (output divisor, input tick);
endinterface

// ### verification/pulse_timer_functions_tb_top.sv
// Self-checking bench for the pulse timer block: registers, wiping relays, pulse generator.
// Assumes ptf_cfg.svh on the include path and the design compiled alongside.
`timescale 1ns/100ps
`include "ptf_cfg.svh"
module pulse_timer_functions_tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        i_mclk;
	logic        i_sys_rst;
	logic [4:0]  pins;
	logic        i_wipe_trg, i_etw_trg, i_etw_rst, i_apg_en, i_apg_inv;
	logic        o_wipe_q, o_etw_q, o_apg_q;
	logic [7:0]  i_axi_awaddr, i_axi_araddr;
	logic [31:0] i_axi_wdata, o_axi_rdata;
	logic [3:0]  i_axi_wstrb;
	logic [1:0]  o_axi_bresp, o_axi_rresp;
	logic        i_axi_awvalid, o_axi_awready, i_axi_wvalid, o_axi_wready, o_axi_bvalid, i_axi_bready;
	logic        i_axi_arvalid, o_axi_arready, o_axi_rvalid, i_axi_rready;
	logic [2:0]  outs;
	logic [31:0] rd;
	logic [1:0]  rsp;
	int          num_errors, comparisons, cycles, n;

	assign i_wipe_trg = pins[`PTF_PIN_WIPE_TRG];
	assign i_etw_trg  = pins[`PTF_PIN_ETW_TRG];
	assign i_etw_rst  = pins[`PTF_PIN_ETW_RST];
	assign i_apg_en   = pins[`PTF_PIN_APG_EN];
	assign i_apg_inv  = pins[`PTF_PIN_APG_INV];
	assign outs       = {o_apg_q, o_etw_q, o_wipe_q};

	ptf_pulse_timers i_dut (.i_mclk, .i_sys_rst, .i_wipe_trg, .i_etw_trg, .i_etw_rst, .i_apg_en, .i_apg_inv,
		.o_wipe_q, .o_etw_q, .o_apg_q, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready, .i_axi_wdata,
		.i_axi_wstrb, .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid, .i_axi_bready,
		.i_axi_araddr, .i_axi_arvalid, .o_axi_arready, .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid,
		.i_axi_rready);

	// ----------------------------------------
	// Bus, pin and compare tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic in_range(input string what, input int v, input int lo, input int hi);
		check(what, 32'(v >= lo && v <= hi), 32'h0000_0001);
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge i_mclk);
		i_axi_awaddr  <= a;
		i_axi_wdata   <= d;
		i_axi_awvalid <= 1'b1;
		i_axi_wvalid  <= 1'b1;
		i_axi_bready  <= 1'b1;
		while (aw || w)
		begin
			@(posedge i_mclk);
			aw = aw && (o_axi_awready !== 1'b1);
			w = w && (o_axi_wready !== 1'b1);
			i_axi_awvalid <= aw;
			i_axi_wvalid  <= w;
		end
		while (o_axi_bvalid !== 1'b1)
			@(posedge i_mclk);
		r = o_axi_bresp;
		i_axi_bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_mclk);
		i_axi_araddr  <= a;
		i_axi_arvalid <= 1'b1;
		i_axi_rready  <= 1'b1;
		do
			@(posedge i_mclk);
		while (o_axi_arready !== 1'b1);
		i_axi_arvalid <= 1'b0;
		while (o_axi_rvalid !== 1'b1)
			@(posedge i_mclk);
		d = o_axi_rdata;
		r = o_axi_rresp;
		i_axi_rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
		axi_read(a, rd, rsp);
		check(what, rd, e);
	endtask

	task automatic set_pin(input int k, input logic v);
		@(posedge i_mclk);
		pins[k] <= v;
	endtask

	// Cycles until output idx shows v, capped at lim
	task automatic wait_out(input int idx, input logic v, input int lim, output int c);
		c = 0;
		while (outs[idx] !== v && c < lim)
		begin
			@(posedge i_mclk);
			c++;
		end
	endtask

	task automatic final_report();
		$display("TB: %0d comparisons, %0d errors", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		rd_chk(`PTF_ADDR_TBASE, 32'h0000_03E7, "tbase_rst");
		rd_chk(`PTF_ADDR_SPAN0, 32'h0000_000A, "span_rst");
		rd_chk(`PTF_ADDR_COUNT, 32'h0000_0001, "count_rst");
		axi_read(8'h40, rd, rsp);
		check("unmapped_resp", rsp, `PTF_RESP_SLVERR);
		check("unmapped_data", rd, 32'h0000_0000);
		axi_write(`PTF_ADDR_TA0, 32'h0000_0005, rsp);
		check("ro_write_resp", rsp, `PTF_RESP_SLVERR);
		rd_chk(`PTF_ADDR_TA0, 32'h0000_0000, "ro_write_kept");
		axi_write(`PTF_ADDR_COUNT, 32'h0000_000C, rsp);
		rd_chk(`PTF_ADDR_COUNT, 32'h0000_0009, "count_clamp_hi");
		axi_write(`PTF_ADDR_COUNT, 32'h0000_0000, rsp);
		rd_chk(`PTF_ADDR_COUNT, 32'h0000_0001, "count_clamp_lo");
		axi_write(`PTF_ADDR_COUNT, 32'h0000_0010, rsp);
		rd_chk(`PTF_ADDR_COUNT, 32'h0000_0009, "count_clamp_wide");
	endtask

	task automatic t_wipe();
		set_pin(`PTF_PIN_WIPE_TRG, 1'b1);
		wait_out(0, 1'b1, 8, n);
		in_range("wipe_rise", n, 1, 5);
		wait_out(0, 1'b0, 40, n);
		in_range("wipe_width", n, 20, 22);
		set_pin(`PTF_PIN_WIPE_TRG, 1'b0);
		repeat (4) @(posedge i_mclk);
		set_pin(`PTF_PIN_WIPE_TRG, 1'b1);
		wait_out(0, 1'b1, 8, n);
		repeat (5) @(posedge i_mclk);
		set_pin(`PTF_PIN_WIPE_TRG, 1'b0);
		wait_out(0, 1'b0, 10, n);
		in_range("wipe_early_end", n, 1, 5);
	endtask

	task automatic t_etw();
		axi_write(`PTF_ADDR_COUNT, 32'h0000_0002, rsp);
		set_pin(`PTF_PIN_ETW_TRG, 1'b1);
		set_pin(`PTF_PIN_ETW_TRG, 1'b0);
		repeat (2)
		begin
			wait_out(1, 1'b1, 20, n);
			in_range("etw_low", n, 4, 11);
			wait_out(1, 1'b0, 20, n);
			in_range("etw_high", n, 3, 5);
		end
		wait_out(1, 1'b1, 40, n);
		check("etw_no_extra", n, 40);
		axi_write(`PTF_ADDR_COUNT, 32'h0000_0001, rsp);
		axi_write(`PTF_ADDR_SPAN0 + 8'h04, 32'h0000_001E, rsp);
		set_pin(`PTF_PIN_ETW_TRG, 1'b1);
		set_pin(`PTF_PIN_ETW_TRG, 1'b0);
		wait_out(1, 1'b1, 20, n);
		set_pin(`PTF_PIN_ETW_TRG, 1'b1);
		set_pin(`PTF_PIN_ETW_TRG, 1'b0);
		wait_out(1, 1'b0, 10, n);
		in_range("retrig_drop", n, 0, 5);
		wait_out(1, 1'b1, 20, n);
		in_range("retrig_low", n, 4, 10);
		set_pin(`PTF_PIN_ETW_RST, 1'b1);
		wait_out(1, 1'b0, 10, n);
		in_range("rst_drop", n, 0, 5);
		rd_chk(`PTF_ADDR_TA0 + 8'h04, 32'h0000_0000, "rst_elapsed");
		set_pin(`PTF_PIN_ETW_RST, 1'b0);
	endtask

	task automatic t_ret();
		axi_write(`PTF_ADDR_SPAN0 + 8'h08, 32'h0000_00C8, rsp);
		axi_write(`PTF_ADDR_CTRL, 32'h0000_0020, rsp);
		set_pin(`PTF_PIN_ETW_TRG, 1'b1);
		set_pin(`PTF_PIN_ETW_TRG, 1'b0);
		repeat (10) @(posedge i_mclk);
		axi_write(`PTF_ADDR_CTRL, 32'h0000_0021, rsp);
		axi_read(`PTF_ADDR_STAT, rd, rsp);
		check("ret_state", rd[5:4], 2'h1);
		axi_read(`PTF_ADDR_TA0 + 8'h04, rd, rsp);
		in_range("ret_elapsed", int'(rd), 10, 199);
		axi_write(`PTF_ADDR_CTRL, 32'h0000_0001, rsp);
		axi_read(`PTF_ADDR_STAT, rd, rsp);
		check("nonret_state", rd[5:4], 2'h0);
		rd_chk(`PTF_ADDR_TA0 + 8'h04, 32'h0000_0000, "nonret_elapsed");
	endtask

	task automatic t_apg();
		set_pin(`PTF_PIN_APG_EN, 1'b1);
		wait_out(2, 1'b1, 8, n);
		in_range("apg_start", n, 1, 5);
		wait_out(2, 1'b0, 20, n);
		in_range("apg_high", n, 4, 6);
		wait_out(2, 1'b1, 20, n);
		in_range("apg_low", n, 9, 11);
		set_pin(`PTF_PIN_APG_INV, 1'b1);
		repeat (4) @(posedge i_mclk);
		wait_out(2, 1'b1, 20, n);
		wait_out(2, 1'b0, 20, n);
		wait_out(2, 1'b1, 20, n);
		in_range("apg_inv_low", n, 4, 6);
		set_pin(`PTF_PIN_APG_EN, 1'b0);
		repeat (4) @(posedge i_mclk);
		wait_out(2, 1'b1, 30, n);
		check("apg_off_low", n, 30);
		// Full wiping pulse leaves elapsed time at its span
		set_pin(`PTF_PIN_WIPE_TRG, 1'b1);
		wait_out(0, 1'b1, 8, n);
		wait_out(0, 1'b0, 40, n);
		set_pin(`PTF_PIN_WIPE_TRG, 1'b0);
		rd_chk(`PTF_ADDR_TA0, 32'h0000_0014, "wipe_elapsed_held");
		// Pulse generator high span taken from wiping relay elapsed time
		axi_write(`PTF_ADDR_SPAN0 + 8'h0C, 32'h0001_0000, rsp);
		set_pin(`PTF_PIN_APG_INV, 1'b0);
		set_pin(`PTF_PIN_APG_EN, 1'b1);
		wait_out(2, 1'b1, 8, n);
		in_range("apg_restart_high", n, 1, 5);
		wait_out(2, 1'b0, 40, n);
		in_range("apg_src_high", n, 19, 22);
		set_pin(`PTF_PIN_APG_EN, 1'b0);
	endtask

	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial
	begin
		i_mclk = 1'b0;
		forever
			#50 i_mclk = ~i_mclk;
	end

	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			final_report();
		end
	end

	initial
	begin
		i_sys_rst = 1'b1;
		pins = 5'h00;
		i_axi_awaddr = 8'h00;
		i_axi_araddr = 8'h00;
		i_axi_wdata = 32'h0000_0000;
		i_axi_wstrb = 4'hF;
		i_axi_awvalid = 1'b0;
		i_axi_wvalid = 1'b0;
		i_axi_bready = 1'b0;
		i_axi_arvalid = 1'b0;
		i_axi_rready = 1'b0;
		repeat (5) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		t_regs();
		// One tick per clock keeps every span short
		axi_write(`PTF_ADDR_TBASE, 32'h0000_0000, rsp);
		axi_write(`PTF_ADDR_SPAN0, 32'h0000_0014, rsp);
		axi_write(`PTF_ADDR_SPAN0 + 8'h04, 32'h0000_0003, rsp);
		axi_write(`PTF_ADDR_SPAN0 + 8'h08, 32'h0000_0005, rsp);
		axi_write(`PTF_ADDR_SPAN0 + 8'h0C, 32'h0000_0004, rsp);
		axi_write(`PTF_ADDR_SPANN, 32'h0000_0009, rsp);
		t_wipe();
		t_etw();
		t_ret();
		t_apg();
		final_report();
	end
endmodule // pulse_timer_functions_tb_top
